// *** rtl/diag_pkg.sv ***
// constants shared by the dual channel diagnosis flag logic
package diag_pkg;
  localparam int          CHANNELS         = 2;
  localparam int          SYS_CLK_MHZ      = 40;
  // fault filter time in microseconds, typical figure
  localparam int          FAULT_FILTER_US  = 100;
  localparam int          FAULT_FILTER_CYC = FAULT_FILTER_US * SYS_CLK_MHZ;
  // overload switch-off delay in microseconds, slew rate 1 upper figure
  localparam int          OVL_OFF_US       = 50;
  localparam int          OVL_OFF_CYC      = OVL_OFF_US * SYS_CLK_MHZ;
  localparam int          FILT_W           = 13;
  localparam int          BITS_PER_FRAME   = 8;
  localparam logic [3:0]  FRAME_BITS       = 4'h8;
  localparam logic [3:0]  BIT_CNT_MAX      = 4'hF;
  // two-bit channel diagnosis codes, msb first
  localparam logic [1:0]  CODE_NORMAL      = 2'h3;
  localparam logic [1:0]  CODE_PROTECT     = 2'h2;
  localparam logic [1:0]  CODE_OPEN_UC     = 2'h1;
  localparam logic [1:0]  CODE_SG_OFF      = 2'h0;
  // diagnosis byte layout
  localparam int          POS_CODE0        = 0;
  localparam int          POS_CODE1        = 2;
  localparam int          POS_OT0          = 4;
  localparam int          POS_OT1          = 5;
  localparam logic [7:0]  DIAG_RESET       = 8'hFF;
endpackage

// *** rtl/fault_filter.sv ***
// persistence filter: output rises once the condition outlasts the limit
`timescale 1ns/1ps
module fault_filter
  import diag_pkg::*;
#(
  parameter int WIDTH = FILT_W
)
(
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             ce_in,
  input  wire logic             cond_in,
  input  wire logic [WIDTH-1:0] limit_in,
  output logic                  hit_out
);
  logic [WIDTH-1:0] count;
  wire              expired = (count == limit_in);

  // any gap in the condition restarts the count
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      count   <= '0;
      hit_out <= 1'b0;
    end
    else if (ce_in)
    begin
      if (!cond_in)
        count <= '0;
      else if (!expired)
        count <= count + 1'b1;
      hit_out <= cond_in && expired;
    end
  end
endmodule

// *** rtl/switch_diag.sv ***
// diagnosis flag logic of a two-channel low-side switch with serial readout
//
// Behaviour
// [R01] overload and overtemp merge into protection flag
// [R02] open load latched, code low-high
// [R03] under current latched, code low-high
// [R04] short ground: code low-low off, low-high on
// [R05] faults except overtemp need filter persistence
// [R06] no fault: status follows input, fault high
// [R07] filtered fault: status shows inverted input
// [R08] status indication unlatched, recovers with fault
// [R09] serial mode latches flags, drives fault low
// [R10] flags clear at end of good frame
// [R11] limiting mode stays on, reports high-low
// [R12] shutdown mode switches off after delay
// [R13] overtemp autorestart, flag immediate, no filter
// [R14] latched overtemp held until input falls
// [R15] latched overtemp flag clears only when off
// [R16] shutdown overload flag kept while input high
`timescale 1ns/1ps
module switch_diag
  import diag_pkg::*;
#(
  parameter int CH       = CHANNELS,
  parameter int FILT_CYC = FAULT_FILTER_CYC,
  parameter int OFF_CYC  = OVL_OFF_CYC
)
(
  input  wire logic          sys_clk_in,
  input  wire logic          rst_n_in,
  input  wire logic          ce_in,
  input  wire logic [CH-1:0] chan_in,
  input  wire logic [CH-1:0] overload_det_in,
  input  wire logic [CH-1:0] overtemp_det_in,
  input  wire logic [CH-1:0] open_load_det_in,
  input  wire logic [CH-1:0] under_current_det_in,
  input  wire logic [CH-1:0] short_ground_det_in,
  input  wire logic [CH-1:0] ovl_shutdown_mode_in,
  input  wire logic [CH-1:0] ot_latch_mode_in,
  input  wire logic          serial_diag_mode_in,
  input  wire logic          spi_clk_in,
  input  wire logic          spi_cs_n_in,
  input  wire logic          spi_mosi_in,
  output logic               spi_miso_out,
  output logic               spi_miso_oe_out,
  output logic [CH-1:0]      channel_on_out,
  output logic [CH-1:0]      channel_status_pin_out,
  output logic               fault_n_out,
  output logic [CH-1:0]      protection_flag_out
);
  localparam int NDET = 5 * CH + 1;
  localparam logic [FILT_W-1:0] FILT_LIM = FILT_W'(FILT_CYC);
  localparam logic [FILT_W-1:0] OFF_LIM  = FILT_W'(OFF_CYC);

  logic [1:0]      rst_pipe;
  wire             rst_n = rst_pipe[1];
  logic [NDET-1:0] det_sync;
  logic [2:0]      done_pipe;
  logic [CH-1:0]   chan_prev;
  logic [CH-1:0]   ovl_latch;
  logic [CH-1:0]   ot_latch;
  logic [CH-1:0]   overload_flag;
  logic [CH-1:0]   overtemp_flag;
  logic [CH-1:0]   open_load_flag;
  logic [CH-1:0]   under_current_flag;
  logic [CH-1:0]   short_ground_flag;
  logic [CH-1:0]   ov_hit;
  logic [CH-1:0]   ol_hit;
  logic [CH-1:0]   uc_hit;
  logic [CH-1:0]   sg_hit;
  logic [7:0]      diag_snapshot;
  logic [7:0]      next_snapshot;
  logic [CH-1:0]   status_level;
  logic            fault_n;
  logic [1:0]      code [CH];
  logic [3:0]      bit_cnt;
  logic [7:0]      shift_reg;
  logic            done_tgl;
  logic            cs_sync_n;

  // reset release through two flops
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rst_pipe <= 2'h0;
    else
      rst_pipe <= {rst_pipe[0], 1'b1};
  end

  // every detector input and the chip select cross two flops before use
  sync_2ff #(.WIDTH(NDET)) u_pin_sync (
    .clk_in   (sys_clk_in),
    .rst_n_in (rst_n),
    .async_in ({spi_cs_n_in, short_ground_det_in, under_current_det_in,
                open_load_det_in, overtemp_det_in, overload_det_in}),
    .sync_out (det_sync)
  );

  wire [CH-1:0] ovl_s = det_sync[CH-1:0];
  wire [CH-1:0] ot_s  = det_sync[2*CH-1:CH];
  wire [CH-1:0] ol_s  = det_sync[3*CH-1:2*CH];
  wire [CH-1:0] uc_s  = det_sync[4*CH-1:3*CH];
  wire [CH-1:0] sg_s  = det_sync[5*CH-1:4*CH];
  assign cs_sync_n    = det_sync[NDET-1];

  logic [CH-1:0] in_s;
  sync_2ff #(.WIDTH(CH)) u_in_sync (
    .clk_in   (sys_clk_in),
    .rst_n_in (rst_n),
    .async_in (chan_in),
    .sync_out (in_s)
  );

  // good-frame toggle: third flop only feeds the edge compare
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      done_pipe <= 3'h0;
    else if (ce_in)
      done_pipe <= {done_pipe[1:0], done_tgl};
  end
  // [R10] clear on good frame
  wire clear_pulse = ce_in && (done_pipe[2] != done_pipe[1]);

  wire [CH-1:0] in_fall = chan_prev & ~in_s;

  genvar n;
  generate
    for (n = 0; n < CH; n++)
    begin : g_ch
      // [R05] filter non-thermal faults
      fault_filter u_ov (
        .clk_in   (sys_clk_in),
        .rst_n_in (rst_n),
        .ce_in    (ce_in),
        .cond_in  (ovl_s[n] && in_s[n] && !ovl_latch[n]),
        // [R12] shutdown delay replaces filter time
        .limit_in (ovl_shutdown_mode_in[n] ? OFF_LIM : FILT_LIM),
        .hit_out  (ov_hit[n])
      );
      fault_filter u_ol (
        .clk_in   (sys_clk_in),
        .rst_n_in (rst_n),
        .ce_in    (ce_in),
        .cond_in  (ol_s[n] && !in_s[n]),
        .limit_in (FILT_LIM),
        .hit_out  (ol_hit[n])
      );
      // [R03] under current only while enabled
      fault_filter u_uc (
        .clk_in   (sys_clk_in),
        .rst_n_in (rst_n),
        .ce_in    (ce_in),
        .cond_in  (uc_s[n] && in_s[n]),
        .limit_in (FILT_LIM),
        .hit_out  (uc_hit[n])
      );
      fault_filter u_sg (
        .clk_in   (sys_clk_in),
        .rst_n_in (rst_n),
        .ce_in    (ce_in),
        .cond_in  (sg_s[n]),
        .limit_in (FILT_LIM),
        .hit_out  (sg_hit[n])
      );
    end
  endgenerate

  // unlatched view for the status pins; overtemp unfiltered
  wire [CH-1:0] prot_live = ov_hit | ovl_latch | ot_s | ot_latch;
  wire [CH-1:0] olu_live  = ol_hit | uc_hit;
  wire [CH-1:0] any_live  = prot_live | olu_live | sg_hit;

  // [R11] limiting mode never switches the channel off on overload; overtemp still does
  // [R13] autorestart: off only while hot
  assign channel_on_out = in_s & ~ot_s & ~ot_latch & ~ovl_latch;

  // set always wins over clear
  wire [CH-1:0] ov_keep  = ovl_shutdown_mode_in & in_s;
  wire [CH-1:0] ot_keep  = ot_latch_mode_in & (in_s | ot_latch);
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chan_prev          <= '0;
      ovl_latch          <= '0;
      ot_latch           <= '0;
      overload_flag      <= '0;
      overtemp_flag      <= '0;
      open_load_flag     <= '0;
      under_current_flag <= '0;
      short_ground_flag  <= '0;
    end
    else if (ce_in)
    begin
      chan_prev <= in_s;
      // [R12] shutdown latch, reset by switching off
      ovl_latch <= (ovl_latch & in_s) | (ov_hit & ovl_shutdown_mode_in);
      // [R14] latch kept until input falls
      ot_latch  <= (ot_latch & ~in_fall) | (ot_s & ot_latch_mode_in);
      // [R09] latched flags
      // [R16] shutdown overload flag kept while input high
      overload_flag <= ov_hit | (overload_flag & ~({CH{clear_pulse}} & ~ov_keep));
      // [R15] latched overtemp clears only once off
      overtemp_flag <= ot_s | (overtemp_flag & ~({CH{clear_pulse}} & ~ot_keep));
      // [R02] open load flag
      open_load_flag     <= ol_hit | (open_load_flag & ~{CH{clear_pulse}});
      under_current_flag <= uc_hit | (under_current_flag & ~{CH{clear_pulse}});
      // [R04] short ground flag
      short_ground_flag  <= sg_hit | (short_ground_flag & ~{CH{clear_pulse}});
    end
  end

  // [R01] protection merge
  wire [CH-1:0] prot_sel = serial_diag_mode_in ? (overload_flag | overtemp_flag) : prot_live;
  wire [CH-1:0] olu_sel  = serial_diag_mode_in ? (open_load_flag | under_current_flag)
                                               : olu_live;
  wire [CH-1:0] sg_sel   = serial_diag_mode_in ? short_ground_flag : sg_hit;
  wire [CH-1:0] any_flag = overload_flag | overtemp_flag | open_load_flag
                         | under_current_flag | short_ground_flag;

  // [R06] code priority, normal is high-high
  always_comb
  begin
    for (int i = 0; i < CH; i++)
    begin
      if (prot_sel[i])
        code[i] = CODE_PROTECT;
      else if (olu_sel[i])
        code[i] = CODE_OPEN_UC;
      else if (sg_sel[i])
        code[i] = in_s[i] ? CODE_OPEN_UC : CODE_SG_OFF;
      else
        code[i] = CODE_NORMAL;
    end
  end

  // snapshot frozen while a frame runs, so the link reads stable bits
  always_comb
  begin
    next_snapshot            = 8'h00;
    next_snapshot[POS_CODE0 +: 2] = code[0];
    next_snapshot[POS_CODE1 +: 2] = code[1];
    next_snapshot[POS_OT0]   = overtemp_flag[0];
    next_snapshot[POS_OT1]   = overtemp_flag[1];
  end

  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      diag_snapshot <= DIAG_RESET;
      status_level  <= '0;
      fault_n       <= 1'b1;
    end
    else if (ce_in)
    begin
      if (cs_sync_n)
        diag_snapshot <= next_snapshot;
      // [R07] inverted input on fault
      // [R08] follows the live fault only
      status_level <= in_s ^ any_live;
      // [R09] fault pin low on latched flag
      fault_n      <= serial_diag_mode_in ? ~|any_flag : ~|any_live;
    end
  end

  assign channel_status_pin_out = status_level;
  assign fault_n_out            = fault_n;
  assign protection_flag_out    = overload_flag | overtemp_flag;

  // link domain: bit counter cleared by the frame's own chip select
  always_ff @(posedge spi_clk_in or posedge spi_cs_n_in)
  begin
    if (spi_cs_n_in)
    begin
      bit_cnt   <= 4'h0;
      shift_reg <= 8'h00;
    end
    else
    begin
      if (bit_cnt != BIT_CNT_MAX)
        bit_cnt <= bit_cnt + 4'h1;
      shift_reg <= (bit_cnt == 4'h0) ? {diag_snapshot[6:0], spi_mosi_in}
                                     : {shift_reg[6:0], spi_mosi_in};
    end
  end

  // [R10] only an exact byte counts as a good frame
  always_ff @(posedge spi_cs_n_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      done_tgl <= 1'b0;
    else if (bit_cnt == FRAME_BITS)
      done_tgl <= ~done_tgl;
  end

  assign spi_miso_out    = (bit_cnt == 4'h0) ? diag_snapshot[7] : shift_reg[7];
  assign spi_miso_oe_out = ~spi_cs_n_in;

  // checks
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n);

  chk_prot_merge: assert property ( // [R01]
    serial_diag_mode_in |-> protection_flag_out[0] == (code[0] == CODE_PROTECT)
                         && protection_flag_out[1] == (code[1] == CODE_PROTECT))
    else $error("protection flag differs from merge");
  chk_ot_immediate: assert property ( // [R13]
    ce_in |-> (channel_on_out & ot_s) == '0 ##1 (overtemp_flag & $past(ot_s)) == $past(ot_s))
    else $error("overtemp not flagged at once");
  chk_filter_short: assert property ( // [R05]
    ce_in && !sg_s[0] ##1 ce_in && sg_s[0] ##1 !sg_s[0] |=> !sg_hit[0])
    else $error("short event recognised");
  chk_status_normal: assert property ( // [R06]
    ce_in && any_live == '0 |=> channel_status_pin_out == $past(in_s))
    else $error("status pin does not follow input");
  chk_status_invert: assert property ( // [R07]
    ce_in && any_live[1] |=> channel_status_pin_out[1] == !$past(in_s[1]))
    else $error("status pin not inverted on fault");
  chk_fault_pin: assert property ( // [R09]
    ce_in && serial_diag_mode_in && any_flag != '0 |=> !fault_n_out)
    else $error("fault pin not low with latched flag");
  chk_clear_flags: assert property ( // [R10]
    clear_pulse && !sg_hit[0] |=> !short_ground_flag[0])
    else $error("flag survived good frame");
  chk_ovl_kept: assert property ( // [R16]
    clear_pulse |=> (overload_flag & $past(overload_flag & ovl_shutdown_mode_in & in_s))
                    == $past(overload_flag & ovl_shutdown_mode_in & in_s))
    else $error("shutdown overload flag cleared while input high");
  chk_ot_latch: assert property ( // [R14]
    ce_in |=> (ot_latch & ~channel_on_out & $past(ot_latch & ~in_fall))
              == $past(ot_latch & ~in_fall))
    else $error("overtemp latch lost without falling input");
  chk_limit_on: assert property ( // [R11]
    ce_in |=> (ovl_latch & ~$past(ovl_shutdown_mode_in | ovl_latch)) == '0)
    else $error("limiting channel switched off");

  cov_good_frame: cover property (clear_pulse);
  cov_ovl_shutdown: cover property (ovl_latch[0] ##[1:20] !ovl_latch[0]);
  cov_sg_off: cover property (sg_hit[1] && !in_s[1]);
endmodule

// *** rtl/sync_2ff.sv ***
// two flip-flop level synchroniser
`timescale 1ns/1ps
module sync_2ff
  import diag_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta     <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// *** tb/spi_master_model.sv ***
// serial master model that clocks the link only inside frames
`timescale 1ns/1ps
module spi_master_model
  import diag_pkg::*;
(
  input  wire logic miso_in,
  output logic      spi_clk_out,
  output logic      cs_n_out,
  output logic      mosi_out
);
  initial
  begin
    spi_clk_out = 1'b0;
    cs_n_out    = 1'b1;
    mosi_out    = 1'b0;
  end

  task automatic frame(input int edges, input int lag, output logic [7:0] rx);
    rx = 8'h00;
    cs_n_out = 1'b0;
    // snapshot must settle across the sync flops first
    #100;
    for (int i = 0; i < edges; i++)
    begin
      mosi_out = ~mosi_out;
      #6;
      rx = {rx[6:0], miso_in};
      spi_clk_out = 1'b1;
      #6;
      spi_clk_out = 1'b0;
    end
    #(20 + lag);
    cs_n_out = 1'b1;
    // unselected data line must not keep its last value
    mosi_out = ~mosi_out;
    #100;
  endtask
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the two-channel diagnosis flag logic
`timescale 1ns/1ps
module tb_top
  import diag_pkg::*;
();
  localparam int FILT = 20;
  localparam int OFF  = 10;
  logic        sys_clk_in;
  logic        rst_n_in;
  logic        ce;
  logic [1:0]  chan_in;
  logic [1:0]  det [5];
  logic [1:0]  shut_mode;
  logic [1:0]  otlatch_mode;
  logic        serial_mode;
  wire         spi_clk;
  wire         cs_n;
  wire         mosi;
  wire         miso;
  logic [1:0]  ch_on;
  logic [1:0]  st;
  logic        fault_n;
  logic [1:0]  prot;
  logic [7:0]  rx;
  logic [31:0] seed;
  int          n_mismatch;
  int          num_checks;
  int          cycles = 0;
  int          c;
  int          lvl [5]  = '{0, 1, 0, 1, 1};
  int          kind [5] = '{2, 3, 4, 4, 0};
  logic [1:0]  code [5] = '{CODE_OPEN_UC, CODE_OPEN_UC, CODE_SG_OFF, CODE_OPEN_UC, CODE_PROTECT};

  switch_diag #(.FILT_CYC(FILT), .OFF_CYC(OFF)) u_switch_diag
  (
    .sys_clk_in             (sys_clk_in),
    .rst_n_in               (rst_n_in),
    .ce_in                  (ce),
    .chan_in                (chan_in),
    .overload_det_in        (det[0]),
    .overtemp_det_in        (det[1]),
    .open_load_det_in       (det[2]),
    .under_current_det_in   (det[3]),
    .short_ground_det_in    (det[4]),
    .ovl_shutdown_mode_in   (shut_mode),
    .ot_latch_mode_in       (otlatch_mode),
    .serial_diag_mode_in    (serial_mode),
    .spi_clk_in             (spi_clk),
    .spi_cs_n_in            (cs_n),
    .spi_mosi_in            (mosi),
    .spi_miso_out           (miso),
    .spi_miso_oe_out        (),
    .channel_on_out         (ch_on),
    .channel_status_pin_out (st),
    .fault_n_out            (fault_n),
    .protection_flag_out    (prot)
  );

  spi_master_model u_spi_master_model
  (
    .miso_in     (miso),
    .spi_clk_out (spi_clk),
    .cs_n_out    (cs_n),
    .mosi_out    (mosi)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // other channel assumed fault free
  function automatic logic [7:0] diag_for(input int ch, input logic [1:0] cd, input logic ot);
    logic [7:0] b;
    b = {4'h0, CODE_NORMAL, CODE_NORMAL};
    b[2*ch +: 2] = cd;
    b[4+ch] = ot;
    return b;
  endfunction

  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic link_read(input int edges);
    u_spi_master_model.frame(edges, int'(seed[3:0]), rx);
    wt(4);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  always @(posedge sys_clk_in)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial
  begin
    seed = 32'h34C986AD;
    rst_n_in = 1'b0;
    chan_in = 2'h0;
    foreach (det[i]) det[i] = 2'h0;
    shut_mode = 2'h0;
    otlatch_mode = 2'h0;
    serial_mode = 1'b0;
    ce = 1'b1;
    n_mismatch = 0;
    num_checks = 0;
    wt(2);
    rst_n_in = 1'b1;
    wt(6);
    chk("fault pin idle", 8'h01, {7'h0, fault_n});
    // status register must hold its reset level while disabled
    ce = 1'b0;
    chan_in = 2'h3;
    wt(6);
    chk("status frozen", 8'h00, {6'h0, st});
    ce = 1'b1;
    // single-cycle event on channel 0 must be filtered away
    det[4][0] = 1'b1;
    wt(1);
    det[4][0] = 1'b0;
    wt(4);
    chk("single cycle pulse", {6'h0, chan_in}, {6'h0, st});
    repeat (4)
    begin
      seed = xs(seed);
      chan_in = seed[1:0];
      c = int'(seed[2]);
      wt(4);
      chk("status follows input", {6'h0, chan_in}, {6'h0, st});
      det[4][c] = 1'b1;
      wt(1 + int'(seed[8:4]) % (FILT - 1));
      det[4][c] = 1'b0;
      wt(4);
      chk("short pulse ignored", {6'h0, chan_in}, {6'h0, st});
      det[4][c] = 1'b1;
      wt(FILT + 6);
      chk("status inverted", {6'h0, chan_in ^ (2'h1 << c)}, {6'h0, st});
      det[4][c] = 1'b0;
      wt(4);
      chk("status recovers", {6'h0, chan_in}, {6'h0, st});
    end
    serial_mode = 1'b1;
    // flags latched unseen during status-pin mode are dropped first
    link_read(8);
    for (int i = 0; i < 5; i++)
    begin
      seed = xs(seed);
      c = int'(seed[0]);
      chan_in = c ? {lvl[i][0], seed[1]} : {seed[2], lvl[i][0]};
      det[kind[i]][c] = 1'b1;
      wt(FILT + 6);
      chk("fault pin latched", 8'h00, {7'h0, fault_n});
      chk("protection flag", {7'h0, kind[i] == 0}, {7'h0, prot[c]});
      chk("channel state", {7'h0, lvl[i][0]}, {7'h0, ch_on[c]});
      det[kind[i]][c] = 1'b0;
      wt(4);
      link_read(7);
      link_read(8);
      chk("latched byte", diag_for(c, code[i], 1'b0), rx);
      link_read(8);
      chk("cleared byte", diag_for(c, CODE_NORMAL, 1'b0), rx);
      chk("fault pin released", 8'h01, {7'h0, fault_n});
    end
    seed = xs(seed);
    c = int'(seed[0]);
    shut_mode[c] = 1'b1;
    chan_in[c] = 1'b1;
    wt(4);
    det[0][c] = 1'b1;
    wt(OFF - 3);
    det[0][c] = 1'b0;
    wt(4);
    chk("short overload ignored", 8'h01, {7'h0, ch_on[c]});
    det[0][c] = 1'b1;
    wt(OFF + 6);
    det[0][c] = 1'b0;
    wt(2);
    chk("shutdown switches off", 8'h00, {7'h0, ch_on[c]});
    link_read(8);
    chk("shutdown byte", diag_for(c, CODE_PROTECT, 1'b0), rx);
    chk("flag kept while on", 8'h01, {7'h0, prot[c]});
    chan_in[c] = 1'b0;
    wt(4);
    link_read(8);
    chk("flag cleared once off", 8'h00, {7'h0, prot[c]});
    chan_in[c] = 1'b1;
    shut_mode[c] = 1'b0;
    wt(4);
    chk("restart after reset", 8'h01, {7'h0, ch_on[c]});
    det[1][c] = 1'b1;
    wt(5);
    chk("overtemp flag at once", 8'h01, {7'h0, prot[c]});
    chk("overtemp switches off", 8'h00, {7'h0, ch_on[c]});
    det[1][c] = 1'b0;
    wt(4);
    chk("autorestart", 8'h01, {7'h0, ch_on[c]});
    link_read(8);
    chk("overtemp byte", diag_for(c, CODE_PROTECT, 1'b1), rx);
    otlatch_mode[c] = 1'b1;
    det[1][c] = 1'b1;
    wt(5);
    det[1][c] = 1'b0;
    wt(4);
    chk("latched overtemp off", 8'h00, {7'h0, ch_on[c]});
    link_read(8);
    link_read(8);
    chk("overtemp kept while on", diag_for(c, CODE_PROTECT, 1'b1), rx);
    chan_in[c] = 1'b0;
    wt(4);
    link_read(8);
    link_read(8);
    chk("overtemp cleared once off", diag_for(c, CODE_NORMAL, 1'b0), rx);
    chan_in[c] = 1'b1;
    wt(4);
    chk("restart after falling input", 8'h01, {7'h0, ch_on[c]});
    tally_and_finish();
  end
endmodule
